// ---- fill_counter.v ----
/*
  Fill level tracker for one FIFO, with flush, full and empty,
  and one-cycle pulses for a push when full outside a flush or a pop when empty.
  Assumes push and pop come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flags_consts.vh"
module fill_counter (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire push,
  input wire pop,
  output reg [`LVL_W-1:0] level,
  output wire full,
  output wire empty,
  output wire push_lost,
  output wire pop_lost
);
  wire do_push;
  wire do_pop;

  assign full = (level == `FIFO_DEPTH);
  assign empty = (level == `LVL_ZERO);
  assign push_lost = push & full & ~flush;
  assign pop_lost = pop & empty;
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= `LVL_ZERO;
    end else if (flush) begin
      level <= `LVL_ZERO;
    end else if (do_push & ~do_pop) begin
      level <= level + `LVL_ONE;
    end else if (do_pop & ~do_push) begin
      level <= level - `LVL_ONE;
    end
  end
endmodule // fill_counter
`default_nettype wire

// ---- i2c_bus_master_model.sv ----
/* Remote master on the two-wire pins: START, three clocks, STOP per go pulse.
   Assumes pull-ups, so both lines rest high between frames. */
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master_model (
  input wire logic go,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Link clock of 200 ns, standing still outside frames
  always @(posedge go) begin
    sda = 1'b0;
    #100 scl = 1'b0;
    repeat (3) begin
      #100 scl = 1'b1;
      #100 scl = 1'b0;
    end
    #100 scl = 1'b1;
    #100 sda = 1'b1;
  end
endmodule // i2c_bus_master_model
`default_nettype wire

// ---- i2c_event_status.v ----
/*
  Event status flags of a two-wire bus controller: twelve sticky or
  level flags, their masked view, the interrupt line, transmit and
  receive fill tracking, and the clock stretch for read requests.
  Every sticky flag keeps an event that lands in its clearing cycle,
  so a clear-read racing an event never hides that event.
  Assumes the protocol engine and processor strobes run on clk;
  the bus pins are asynchronous and are synchronised here.
  Software must write the data port to end a stretch.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2c_flags_consts.vh"
module i2c_event_status (
  input wire clk,
  input wire rst,
  // Bus pins
  input wire scl_in,
  input wire sda_in,
  output reg scl_out,
  output reg scl_oe,
  // Protocol engine events
  input wire fsm_active,
  input wire gen_call_ack,
  input wire rx_byte_valid,
  input wire slave_tx_nack,
  input wire tx_abort_event,
  input wire [`CAUSE_W-1:0] tx_abort_cause,
  input wire read_request_event,
  input wire tx_pop,
  // Processor side
  input wire controller_enable_bit,
  input wire [`EVT_W-1:0] event_mask_reg,
  input wire [`LVL_W-1:0] transmit_threshold_reg,
  input wire [`LVL_W-1:0] receive_threshold_reg,
  input wire data_command_write,
  input wire data_command_read,
  input wire general_call_clear_read,
  input wire activity_clear_read,
  input wire combined_clear_read,
  input wire abort_clear_read,
  input wire read_request_clear_read,
  output reg [`STAT_W-1:0] masked_event_status,
  output reg [`EVT_W-1:0] raw_event_status,
  output reg intr,
  output reg [`CAUSE_W-1:0] abort_cause_reg,
  output reg internal_enable_signal,
  output reg tx_accept,
  output reg [`LVL_W-1:0] tx_level,
  output reg [`LVL_W-1:0] rx_level
);
  // ---------------------------------------------------------------
  // Pin synchronisation and bus condition detection
  // ---------------------------------------------------------------
  wire [1:0] pins_s;
  reg scl_d;
  reg sda_d;
  wire scl_s;
  wire sda_s;
  wire start_seen;
  wire stop_seen;

  pin_sync #(
    .W(2),
    .INIT(2'h3)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({scl_in, sda_in}),
    .q(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Delay flops reset to the idle-high level so no edge follows reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Data moving while the clock stays high marks START or STOP
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  // ---------------------------------------------------------------
  // Internal enable
  // ---------------------------------------------------------------
  // Enable rises at once but falls only when the state machines are
  // idle, so a transfer in flight is never cut short.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_enable_signal <= 1'b0;
    end else if (controller_enable_bit) begin
      internal_enable_signal <= 1'b1;
    end else if (!fsm_active) begin
      internal_enable_signal <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // FIFO fill tracking
  // ---------------------------------------------------------------
  reg f_tx_abrt;
  wire tx_flush;
  wire rx_flush;
  wire [`LVL_W-1:0] tx_lvl;
  wire [`LVL_W-1:0] rx_lvl;
  wire tx_full;
  wire rx_empty;
  wire tx_over_pulse;
  wire rx_over_pulse;
  wire rx_under_pulse;

  assign tx_flush = ~controller_enable_bit | f_tx_abrt;
  assign rx_flush = ~controller_enable_bit;

  fill_counter u_tx_fill (
    .clk(clk),
    .rst(rst),
    .flush(tx_flush),
    .push(data_command_write),
    .pop(tx_pop),
    .level(tx_lvl),
    .full(tx_full),
    .empty(),
    .push_lost(tx_over_pulse),
    .pop_lost()
  );

  // General-call payload arrives as ordinary received bytes
  fill_counter u_rx_fill (
    .clk(clk),
    .rst(rst),
    .flush(rx_flush),
    .push(rx_byte_valid),
    .pop(data_command_read),
    .level(rx_lvl),
    .full(),
    .empty(rx_empty),
    .push_lost(rx_over_pulse),
    .pop_lost(rx_under_pulse)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_level <= `LVL_ZERO;
      rx_level <= `LVL_ZERO;
      tx_accept <= 1'b0;
    end else begin
      tx_level <= tx_lvl;
      rx_level <= rx_lvl;
      // No new bytes while an abort holds the FIFO flushed
      tx_accept <= controller_enable_bit & ~f_tx_abrt & ~tx_full;
    end
  end

  // ---------------------------------------------------------------
  // Sticky event flags
  // ---------------------------------------------------------------
  // Every sticky flag uses set | (flag & ~clear): an event landing in
  // the clearing cycle is kept.
  reg f_gen_call;
  reg f_start;
  reg f_stop;
  reg f_activity;
  reg f_rx_done;
  reg f_rd_req;
  reg f_tx_empty;
  reg f_tx_over;
  reg f_rx_full;
  reg f_rx_over;
  reg f_rx_under;
  wire disabled;
  wire en_gone;

  assign disabled = ~controller_enable_bit;
  assign en_gone = ~internal_enable_signal;

  // Disable wipes the bus-event flags; abort and read request stay
  // because software still owes them an explicit clear-read.
  wire gen_call_clr;
  wire event_clr;
  wire activity_clr;
  wire abort_clr;
  wire rd_req_clr;
  wire error_clr;

  assign gen_call_clr = disabled | general_call_clear_read | combined_clear_read;
  assign event_clr = disabled | combined_clear_read;
  assign activity_clr = disabled | activity_clear_read | combined_clear_read;
  assign abort_clr = abort_clear_read | combined_clear_read;
  assign rd_req_clr = read_request_clear_read | combined_clear_read;
  // Error flags wait for the engine to go idle, not for the enable bit
  assign error_clr = en_gone | combined_clear_read;

  // Next values of the event flags; set beats clear in every term.
  // Keeping them apart lets one process hold every clear condition.
  reg next_gen_call;
  reg next_start;
  reg next_stop;
  reg next_activity;
  reg next_rx_done;
  reg next_tx_abrt;
  reg next_rd_req;
  reg next_tx_over;
  reg next_rx_over;
  reg next_rx_under;

  always @* begin
    next_gen_call = gen_call_ack | (f_gen_call & ~gen_call_clr);
    next_start = start_seen | (f_start & ~event_clr);
    next_stop = stop_seen | (f_stop & ~event_clr);
    next_activity = fsm_active | start_seen | (f_activity & ~activity_clr);
    next_rx_done = slave_tx_nack | (f_rx_done & ~event_clr);
    next_tx_abrt = tx_abort_event | (f_tx_abrt & ~abort_clr);
    next_rd_req = read_request_event | (f_rd_req & ~rd_req_clr);
    next_tx_over = tx_over_pulse | (f_tx_over & ~error_clr);
    next_rx_over = rx_over_pulse | (f_rx_over & ~error_clr);
    next_rx_under = rx_under_pulse | (f_rx_under & ~error_clr);
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      f_gen_call <= 1'b0;
      f_start <= 1'b0;
      f_stop <= 1'b0;
      f_activity <= 1'b0;
      f_rx_done <= 1'b0;
      f_tx_abrt <= 1'b0;
      f_rd_req <= 1'b0;
    end else begin
      f_gen_call <= next_gen_call;
      f_start <= next_start;
      f_stop <= next_stop;
      f_activity <= next_activity;
      f_rx_done <= next_rx_done;
      f_tx_abrt <= next_tx_abrt;
      f_rd_req <= next_rd_req;
    end
  end

  // Error flags survive a disable until the engine has gone idle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      f_tx_over <= 1'b0;
      f_rx_over <= 1'b0;
      f_rx_under <= 1'b0;
    end else begin
      f_tx_over <= next_tx_over;
      f_rx_over <= next_rx_over;
      f_rx_under <= next_rx_under;
    end
  end

  // ---------------------------------------------------------------
  // Level flags from fill thresholds
  // ---------------------------------------------------------------
  // Level flags follow the fill counts while enabled and never latch
  reg next_tx_empty;
  reg next_rx_full;

  always @* begin
    if (controller_enable_bit) begin
      next_tx_empty = (tx_lvl <= transmit_threshold_reg);
    end else begin
      // Flushed FIFO looks empty only while the engine still works
      next_tx_empty = fsm_active;
    end
    // Disable flushes the receive side, so the flag drops at once
    next_rx_full = controller_enable_bit & (rx_lvl >= receive_threshold_reg);
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      f_tx_empty <= 1'b0;
      f_rx_full <= 1'b0;
    end else begin
      f_tx_empty <= next_tx_empty;
      f_rx_full <= next_rx_full;
    end
  end

  // ---------------------------------------------------------------
  // Abort cause capture
  // ---------------------------------------------------------------
  // The cause stays until the next abort; clear-reads leave it alone
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_cause_reg <= `CAUSE_RST;
    end else if (tx_abort_event) begin
      abort_cause_reg <= tx_abort_cause;
    end
  end

  // ---------------------------------------------------------------
  // Clock stretch for remote reads
  // ---------------------------------------------------------------
  // Held until the processor supplies the byte; the flag clear alone
  // does not release the bus, so software must write the data port.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      if (read_request_event) begin
        scl_oe <= 1'b1;
      end else if (data_command_write) begin
        scl_oe <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status view and interrupt
  // ---------------------------------------------------------------
  wire [`EVT_W-1:0] raw_now;
  wire [`EVT_W-1:0] masked_now;

  assign raw_now = {f_gen_call, f_start, f_stop, f_activity, f_rx_done, f_tx_abrt,
                    f_rd_req, f_tx_empty, f_tx_over, f_rx_full, f_rx_over, f_rx_under};
  assign masked_now = raw_now & event_mask_reg;

  // Bits 15 to 12 have no flag behind them and read as zero
  // Views trail the flags by one cycle so all outputs come from flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      raw_event_status <= `EVT_RST;
      masked_event_status <= `STAT_RST;
      intr <= 1'b0;
    end else begin
      raw_event_status <= raw_now;
      masked_event_status <= {`UPPER_ZERO, masked_now};
      intr <= |masked_now;
    end
  end
endmodule // i2c_event_status
`default_nettype wire

// ---- i2c_event_status_monitor.sv ----
/* Checker bound to the event status block: flag timing, masked view, interrupt, stretch.
   Assumes clk at 40 MHz and rst asynchronous, active high. */
`timescale 1ns/1ps
`default_nettype none
module i2c_event_status_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic gen_call_ack,
  input wire logic read_request_event,
  input wire logic data_command_write,
  input wire logic data_command_read,
  input wire logic controller_enable_bit,
  input wire logic activity_clear_read,
  input wire logic combined_clear_read,
  input wire logic [15:0] masked_event_status,
  input wire logic [11:0] raw_event_status,
  input wire logic intr,
  input wire logic scl_oe,
  input wire logic tx_accept,
  input wire logic [5:0] tx_level,
  input wire logic [5:0] rx_level
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_gen_call; $past(gen_call_ack, 2) |-> raw_event_status[11]; endproperty
  a_gen_call: assert property (p_gen_call) else $error("general call flag missing");
  property p_upper; masked_event_status[15:12] == 4'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper status bits not zero");
  // Stable view for a cycle lets intr catch up whichever flop it is taken from
  property p_intr; $stable(masked_event_status) |-> intr == (|masked_event_status[11:0]); endproperty
  a_intr: assert property (p_intr) else $error("interrupt disagrees with status");
  property p_stretch; read_request_event |=> scl_oe; endproperty
  a_stretch: assert property (p_stretch) else $error("clock not stretched");
  property p_release; data_command_write && !read_request_event |=> !scl_oe; endproperty
  a_release: assert property (p_release) else $error("clock not released");
  // Level outputs trail the counter by one cycle, so the read is judged one edge later
  property p_rx_under;
    $past(data_command_read) && rx_level == 6'h00 |-> ##1 raw_event_status[0];
  endproperty
  a_rx_under: assert property (p_rx_under) else $error("underflow flag missing");
  property p_tx_over;
    $past(data_command_write && controller_enable_bit) && tx_level == 6'h20 && !raw_event_status[6]
      |-> ##1 raw_event_status[3];
  endproperty
  a_tx_over: assert property (p_tx_over) else $error("overflow flag missing");
  property p_rx_off; !controller_enable_bit ##1 !controller_enable_bit |=> !raw_event_status[2]; endproperty
  a_rx_off: assert property (p_rx_off) else $error("threshold flag kept while off");
  // The flush lands one cycle after the flag, so the level is judged from the second cycle on
  property p_abort;
    raw_event_status[6] |-> !tx_accept && (!$past(raw_event_status[6]) || tx_level == 6'h00);
  endproperty
  a_abort: assert property (p_abort) else $error("transmit buffer not flushed");
  property p_act;
    raw_event_status[8] && $past(!activity_clear_read && !combined_clear_read && controller_enable_bit)
      |=> raw_event_status[8];
  endproperty
  a_act: assert property (p_act) else $error("activity flag lost");
  c_stretch: cover property (read_request_event ##1 scl_oe);
  c_tx_over: cover property (raw_event_status[3]);
  c_rx_over: cover property (raw_event_status[1] && rx_level == 6'h20);
endmodule // i2c_event_status_monitor
bind i2c_event_status i2c_event_status_monitor u_mon (.*);
`default_nettype wire

// ---- i2c_event_status_tb_top.sv ----
/* Bench for the event status block: random bursts, clears, fill corners, bus frame.
   Assumes the checker is bound and the bus model drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module i2c_event_status_tb_top;
  localparam int GC = 0, RXB = 1, NK = 2, AB = 3, RQ = 4, POP = 5, WR = 6, RD = 7;
  localparam int C_GC = 8, C_ACT = 9, C_ALL = 10, C_AB = 11, C_RQ = 12;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [12:0] st = '0;
  logic fsm = 1'b0, en = 1'b0, go_bus = 1'b0;
  logic [11:0] mask = 12'hfff, exp;
  logic [5:0] tthr = 6'h00, rthr = 6'h01;
  logic [15:0] cause = 16'h0000;
  wire scl, sda, scl_out, scl_oe, intr, ien, tx_ok;
  wire [15:0] masked, cause_q;
  wire [11:0] raw;
  wire [5:0] tx_lvl, rx_lvl;
  wire scl_bus = scl & ~scl_oe;
  int errors = 0, checks_done = 0;
  logic [31:0] r;
  always #12.5 clk = ~clk;
  i2c_bus_master_model u_bus (.go(go_bus), .scl(scl), .sda(sda));
  i2c_event_status u_dut (.clk(clk), .rst(rst), .scl_in(scl_bus), .sda_in(sda), .scl_out(scl_out),
    .scl_oe(scl_oe), .fsm_active(fsm), .gen_call_ack(st[GC]), .rx_byte_valid(st[RXB]),
    .slave_tx_nack(st[NK]), .tx_abort_event(st[AB]), .tx_abort_cause(cause), .read_request_event(st[RQ]),
    .tx_pop(st[POP]), .controller_enable_bit(en), .event_mask_reg(mask), .transmit_threshold_reg(tthr),
    .receive_threshold_reg(rthr), .data_command_write(st[WR]), .data_command_read(st[RD]),
    .general_call_clear_read(st[C_GC]), .activity_clear_read(st[C_ACT]), .combined_clear_read(st[C_ALL]),
    .abort_clear_read(st[C_AB]), .read_request_clear_read(st[C_RQ]), .masked_event_status(masked),
    .raw_event_status(raw), .intr(intr), .abort_cause_reg(cause_q), .internal_enable_signal(ien),
    .tx_accept(tx_ok), .tx_level(tx_lvl), .rx_level(rx_lvl));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [12:0] s(input int i);
    return 13'h0001 << i;
  endfunction
  function automatic logic [15:0] view(input logic [11:0] f, input logic [11:0] m);
    return {4'h0, f & m};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Strobes held n cycles back to back, then three cycles for the view to settle
  task automatic go(input logic [12:0] m, input int n);
    @(negedge clk);
    st = m;
    repeat (n) @(negedge clk);
    st = '0;
    repeat (3) @(negedge clk);
  endtask
  task automatic idle();
    repeat (4) @(negedge clk);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    // Whole run is near 300 cycles; 50 us leaves ample margin
    #50000;
    errors++;
    results();
  end
  initial begin
    void'($urandom(34942));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(masked, 16'h0000);
    en = 1'b1;
    go(s(C_ALL), 1);
    exp = 12'h010;
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      mask = r[27:16];
      cause = $urandom;
      go({8'h00, r[3], r[2], r[1], 1'b0, r[0]}, 1);
      exp = exp | {r[0], 3'b000, r[1], r[2], r[3], 5'b00000};
      chk(masked, view(exp, mask));
      chk(intr, |(exp & mask));
      if (r[2]) chk(cause_q, cause);
    end
    mask = 12'hfff;
    go(s(GC) | s(NK) | s(AB) | s(RQ), 1);
    chk(raw, 12'h8f0);
    chk(scl_oe, 1'b1);
    chk(scl_out, 1'b0);
    chk(tx_ok, 1'b0);
    go(s(WR), 2);
    chk(tx_lvl, 6'h00);
    chk(scl_oe, 1'b0);
    go(s(C_GC), 1);
    chk(raw, 12'h0f0);
    go(s(C_RQ), 1);
    chk(raw, 12'h0d0);
    go(s(C_AB), 1);
    chk(raw, 12'h090);
    chk(tx_ok, 1'b1);
    go(s(C_ALL), 1);
    chk(raw, 12'h010);
    go_bus = 1'b1;
    repeat (80) @(negedge clk);
    go_bus = 1'b0;
    chk(raw[10], 1'b1);
    chk(raw[9], 1'b1);
    go(s(C_ACT), 1);
    chk(raw, 12'h610);
    tthr = 6'($urandom_range(30, 1));
    go(s(WR), tthr);
    chk(raw[4], 1'b1);
    go(s(WR), 1);
    chk(raw[4], 1'b0);
    go(s(WR), 31 - tthr);
    go(s(WR), 1);
    chk(tx_lvl, 6'h20);
    chk(raw[3], 1'b1);
    fsm = 1'b1;
    en = 1'b0;
    idle();
    chk(raw[3], 1'b1);
    chk(raw[4], 1'b1);
    chk(tx_lvl, 6'h00);
    fsm = 1'b0;
    idle();
    chk({ien, raw[4], raw[3]}, 3'b000);
    en = 1'b1;
    rthr = 6'($urandom_range(30, 2));
    go(s(RXB), rthr - 1);
    chk(raw[2], 1'b0);
    go(s(RXB), 1);
    chk(raw[2], 1'b1);
    go(s(RXB), 32 - rthr);
    go(s(RXB), 1);
    chk(rx_lvl, 6'h20);
    chk(raw[1], 1'b1);
    fsm = 1'b1;
    en = 1'b0;
    idle();
    chk(raw[2], 1'b0);
    chk(raw[1], 1'b1);
    fsm = 1'b0;
    idle();
    chk(raw[1], 1'b0);
    en = 1'b1;
    go(s(GC) | s(RXB), 1);
    chk(rx_lvl, 6'h01);
    go(s(RD), 2);
    chk(raw[0], 1'b1);
    results();
  end
endmodule // i2c_event_status_tb_top
`default_nettype wire

// ---- i2c_flags_consts.vh ----
/*
  Constants for the two-wire controller event status logic: register
  address, status bit positions, field widths, reset values, FIFO depth.
  Assumes it is included by bare name from the design files.
*/
// Function
// - General-call flag bit 11 set on acknowledged general call; disable or clear-read clears.
// - Bytes after an acknowledged general call go into the receive buffer.
// - Bit 10 reports START or repeated START in master and slave roles.
// - Bit 9 reports STOP in master and slave roles.
// - Bit 8 latches activity; cleared by disable, activity or combined clear-read, reset.
// - Bit 7 set when master withholds acknowledge while we are slave transmitter.
// - Bit 6 set on transmit abort; cause captured in abort cause register.
// - While abort flag set, transmit FIFO held empty; accepts bytes after clear-read.
// - Remote read request sets bit 5 and stretches clock low until serviced.
// - Read-request flag clears right after its clear register is read.
// - Bit 4 high while transmit level at or below threshold.
// - Disabled: transmit FIFO flushed; bit 4 follows state machine activity.
// - Bit 3 set when data port written with transmit buffer holding 32.
// - Bit 2 high while receive level at or above threshold.
// - Disable flushes receive FIFO and clears bit 2 at once.
// - Byte arriving with receive buffer at 32 is acknowledged, dropped, sets bit 1.
// - Bit 0 set when data port read while receive buffer empty.
// - After disable, overflow and underflow flags hold until internal enable drops.
// - Each raw flag gated by its own mask bit into masked status.
`ifndef I2C_FLAGS_CONSTS_VH
`define I2C_FLAGS_CONSTS_VH

`define STAT_ADDR 32'h5000132c
`define STAT_W 16
`define EVT_W 12
`define STAT_RST 16'h0000
`define EVT_RST 12'h000
`define UPPER_ZERO 4'h0
`define MASK_RST 12'h8ff

`define BIT_GEN_CALL 11
`define BIT_START 10
`define BIT_STOP 9
`define BIT_ACTIVITY 8
`define BIT_RX_DONE 7
`define BIT_TX_ABRT 6
`define BIT_RD_REQ 5
`define BIT_TX_EMPTY 4
`define BIT_TX_OVER 3
`define BIT_RX_FULL 2
`define BIT_RX_OVER 1
`define BIT_RX_UNDER 0

`define FIFO_DEPTH 6'd32
`define LVL_W 6
`define LVL_ZERO 6'h00
`define LVL_ONE 6'h01
`define CAUSE_W 16
`define CAUSE_RST 16'h0000

`endif

// ---- pin_sync.v ----
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes inputs are asynchronous to clk; output is safe to use.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 2,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire
